// File: scc_map.vh
// Register map, control bit positions, reset values and timing for the servo channel block
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// Register addresses
`define SCC_POS_BASE 8'h01
`define SCC_CTRL_BASE 8'h02
`define SCC_CH_STRIDE 2
`define SCC_SERVO12_POS_ADDR 8'h17
`define SCC_GLOBAL_ADDR 8'h25

// Control byte fields
`define SCC_CTRL_REVERSE 6
`define SCC_CTRL_SOFT 5
`define SCC_CTRL_SPEED_EN 4
`define SCC_SPEED_MSB 3
`define SCC_SPEED_LSB 0

// Reset values
`define SCC_POS_RESET 8'h80
`define SCC_CTRL_RESET 8'h00
`define SCC_GLOBAL_RESET 8'h00

// Timing: times in microseconds, counts derived from the clock rate
`define SCC_CLK_MHZ 50
`define SCC_FRAME_US 20000
`define SCC_PULSE_MIN_US 1000
`define SCC_PULSE_UNIT_US 4
`define SCC_FRAME_CYCLES (`SCC_FRAME_US * `SCC_CLK_MHZ)
`define SCC_PULSE_MIN_CYCLES (`SCC_PULSE_MIN_US * `SCC_CLK_MHZ)
`define SCC_PULSE_UNIT_CYCLES (`SCC_PULSE_UNIT_US * `SCC_CLK_MHZ)

// Position steps per frame while a soft start ramps
`define SCC_SOFT_STEP 8'h01

`endif

// File: scc_pulse_out.v
// Per-channel servo pulse generator driven by the shared frame counter
`timescale 1ns/1ps
module scc_pulse_out #(
    parameter CNT_W = 20,
    parameter PULSE_MIN_CYCLES = 50000,
    parameter PULSE_UNIT_CYCLES = 200
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Frame timing and channel state
    input wire [CNT_W-1:0] frameCnt,
    input wire enable,
    input wire [7:0] position,
    // Servo output
    output reg pulseOut
);
    localparam [CNT_W-1:0] MIN_C = PULSE_MIN_CYCLES;
    localparam [CNT_W-1:0] UNIT_C = PULSE_UNIT_CYCLES;

    wire [CNT_W+7:0] product;
    wire [CNT_W-1:0] widthCycles;

    assign product = position * UNIT_C;
    assign widthCycles = product[CNT_W-1:0] + MIN_C;

    // Pulse starts at each frame start; width grows linearly with position
    always @(posedge core_clk) begin
        if (!rstn) begin
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= enable && (frameCnt < widthCycles); // (RULE7)
        end
    end
endmodule // scc_pulse_out

// File: scc_servo_control.v
// Eighteen-channel servo control: registers, global activation, motion and pulse outputs
// Function
// (RULE1) Reverse bit set: channel position is mirrored to the opposite end of travel.
// (RULE2) Soft-start bit at first activation: ramp pulses gradually up to commanded position.
// (RULE3) Speed-enable bit set: movement rate limited by the four-bit speed field.
// (RULE4) Speed field 0 to 15; 0 is slowest, larger values move faster.
// (RULE5) Host writes global register last; new positions apply only on that write.
// (RULE6) Servo channel 12 position is held in register 23.
// (RULE7) Periodic pulse per channel, width tracks activated position, held until next activation.
`timescale 1ns/1ps
`include "scc_map.vh"
module scc_servo_control #(
    parameter CH = 18,
    parameter FRAME_CYCLES = `SCC_FRAME_CYCLES,
    parameter PULSE_MIN_CYCLES = `SCC_PULSE_MIN_CYCLES,
    parameter PULSE_UNIT_CYCLES = `SCC_PULSE_UNIT_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Register port from the serial-bus slave
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData,
    // Servo side
    output wire [CH-1:0] servoPulse,
    output wire [CH-1:0] servoMoving
);
    localparam CNT_W = 20;
    localparam [CNT_W-1:0] FRAME_LAST = FRAME_CYCLES - 1;

    // Address of a per-channel register; channels sit two registers apart
    function [7:0] chAddr;
        input [7:0] base;
        input integer idx;
        integer t;
        begin
            t = base + idx * `SCC_CH_STRIDE;
            chAddr = t[7:0];
        end
    endfunction

    // Move one step from cur toward tgt without overshoot
    function [7:0] stepToward;
        input [7:0] cur;
        input [7:0] tgt;
        input [7:0] step;
        reg [7:0] diff;
        begin
            if (cur < tgt) begin
                diff = tgt - cur;
                stepToward = (diff <= step) ? tgt : cur + step;
            end else begin
                diff = cur - tgt;
                stepToward = (diff <= step) ? tgt : cur - step;
            end
        end
    endfunction

    // Address decode shared by the write strobes and the readback mux
    function regMatch;
        input [7:0] addr;
        input [7:0] base;
        input integer idx;
        begin
            regMatch = (addr == chAddr(base, idx));
        end
    endfunction

    // Step per frame: a soft start crawls, otherwise speed 0 is one step and 15 is sixteen
    function [7:0] stepFor;
        input softOn;
        input [3:0] speed;
        begin
            if (softOn) begin
                stepFor = `SCC_SOFT_STEP;
            end else begin
                stepFor = {4'h0, speed} + 8'h01;
            end
        end
    endfunction

    reg [CNT_W-1:0] frameCnt_reg;
    reg [7:0] globalActivate_reg;
    reg [7:0] rdValue;
    wire frameTick;
    wire activate;
    wire [8*CH-1:0] posFlat;
    wire [8*CH-1:0] ctrlFlat;
    integer k;

    // Shared frame timebase; one tick per servo frame paces soft-start and speed-limited steps
    assign frameTick = (frameCnt_reg == FRAME_LAST);

    always @(posedge core_clk) begin
        if (!rstn) begin
            frameCnt_reg <= {CNT_W{1'b0}};
        end else if (frameTick) begin
            frameCnt_reg <= {CNT_W{1'b0}};
        end else begin
            frameCnt_reg <= frameCnt_reg + 1'b1;
        end
    end

    // A write to the global register releases every pending position at once
    assign activate = regWrEn && (regAddr == `SCC_GLOBAL_ADDR); // (RULE5)

    always @(posedge core_clk) begin
        if (!rstn) begin
            globalActivate_reg <= `SCC_GLOBAL_RESET;
        end else if (activate) begin
            globalActivate_reg <= regWrData;
        end
    end

    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1) begin : chan
            reg [7:0] pos_reg;
            reg [7:0] ctrl_reg;
            reg [7:0] target_reg;
            reg [7:0] current_reg;
            reg [3:0] speed_reg;
            reg speedEn_reg;
            reg soft_reg;
            reg armed_reg;
            wire posHit;
            wire ctrlHit;
            wire [7:0] mapped;
            wire firstSoft;
            wire [7:0] stepSize;
            wire [7:0] stepped;

            // Channel 12 lands on register 23 through this stride
            assign posHit = regWrEn && regMatch(regAddr, `SCC_POS_BASE, i); // (RULE6)
            assign ctrlHit = regWrEn && regMatch(regAddr, `SCC_CTRL_BASE, i);

            // Mirror about the midpoint: 255 - p
            assign mapped = ctrl_reg[`SCC_CTRL_REVERSE] ? ~pos_reg : pos_reg; // (RULE1)
            assign firstSoft = ~armed_reg & ctrl_reg[`SCC_CTRL_SOFT]; // (RULE2)
            // A finished ramp hands over to the latched speed setting
            assign stepSize = stepFor(soft_reg, speed_reg); // (RULE4)
            assign stepped = stepToward(current_reg, target_reg, stepSize);

            always @(posedge core_clk) begin
                if (!rstn) begin
                    pos_reg <= `SCC_POS_RESET;
                    ctrl_reg <= `SCC_CTRL_RESET;
                    target_reg <= `SCC_POS_RESET;
                    current_reg <= `SCC_POS_RESET;
                    speed_reg <= 4'h0;
                    speedEn_reg <= 1'b0;
                    soft_reg <= 1'b0;
                    armed_reg <= 1'b0;
                end else begin
                    if (posHit) begin
                        pos_reg <= regWrData;
                    end
                    if (ctrlHit) begin
                        ctrl_reg <= regWrData;
                    end
                    if (activate) begin
                        // Staged values only reach the motion logic here
                        target_reg <= mapped; // (RULE5)
                        speedEn_reg <= ctrl_reg[`SCC_CTRL_SPEED_EN]; // (RULE3)
                        speed_reg <= ctrl_reg[`SCC_SPEED_MSB:`SCC_SPEED_LSB]; // (RULE3)
                        armed_reg <= 1'b1;
                        if (firstSoft) begin
                            // Ramp from the short end so the servo is not jerked
                            soft_reg <= 1'b1; // (RULE2)
                            current_reg <= 8'h00;
                        end else if (!ctrl_reg[`SCC_CTRL_SPEED_EN] && !soft_reg) begin
                            current_reg <= mapped; // (RULE7)
                        end
                    end else if (frameTick && (soft_reg || speedEn_reg)) begin
                        current_reg <= stepped; // (RULE3)
                        if (soft_reg && (stepped == target_reg)) begin
                            soft_reg <= 1'b0; // (RULE2)
                        end
                    end
                end
            end

            assign servoMoving[i] = armed_reg && (current_reg != target_reg);
            assign posFlat[8*i+7:8*i] = pos_reg;
            assign ctrlFlat[8*i+7:8*i] = ctrl_reg;

            // No pulses before the first activation, so unset servos stay limp
            scc_pulse_out #(
                .CNT_W(CNT_W),
                .PULSE_MIN_CYCLES(PULSE_MIN_CYCLES),
                .PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)
            ) u_pulse (
                .core_clk(core_clk),
                .rstn(rstn),
                .frameCnt(frameCnt_reg),
                .enable(armed_reg),
                .position(current_reg),
                .pulseOut(servoPulse[i])
            );
        end
    endgenerate

    // Readback of staged registers; unmapped addresses read zero
    always @* begin
        rdValue = 8'h00;
        if (regAddr == `SCC_GLOBAL_ADDR) begin
            rdValue = globalActivate_reg;
        end
        for (k = 0; k < CH; k = k + 1) begin
            if (regMatch(regAddr, `SCC_POS_BASE, k)) begin
                rdValue = posFlat[8*k +: 8];
            end
            if (regMatch(regAddr, `SCC_CTRL_BASE, k)) begin
                rdValue = ctrlFlat[8*k +: 8];
            end
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= rdValue;
        end
    end
endmodule // scc_servo_control

// File: scc_servo_model.sv
// Servo stand-in that measures the high time of one pulse output
`timescale 1ns/1ps
module scc_servo_model (
    // Clock and servo pulse
    input wire core_clk,
    input wire servoIn,
    // Last width seen and number of pulses seen
    output wire [15:0] widthSeen,
    output wire [15:0] pulseCount
);
    // Counts from time zero; a mid-run reset of the block does not clear it
    logic [15:0] runCnt = 16'h0000;
    logic [15:0] widthHold = 16'h0000;
    logic [15:0] countHold = 16'h0000;
    assign widthSeen = widthHold;
    assign pulseCount = countHold;
    always @(posedge core_clk) begin
        if (servoIn) begin
            runCnt <= runCnt + 16'h0001;
        end else if (runCnt != 16'h0000) begin
            widthHold <= runCnt;
            countHold <= countHold + 16'h0001;
            runCnt <= 16'h0000;
        end
    end
endmodule // scc_servo_model

// File: scc_servo_control_sva.sv
// Assertions on the register port and pulse outputs of the servo block
`timescale 1ns/1ps
module scc_servo_control_sva #(
    parameter CH = 18
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Register port
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData,
    // Servo side
    input wire [CH-1:0] servoPulse,
    input wire [CH-1:0] servoMoving
);
    // Set by the first global write after reset
    logic armed_reg;
    always @(posedge core_clk) armed_reg <= rstn && (armed_reg || (regWrEn && regAddr == 8'h25));
    property p_rd_reset; @(posedge core_clk) !rstn |=> regRdData == 8'h00; endproperty
    a_rd_reset: assert property (p_rd_reset) else $error("read data not cleared");
    property p_out_reset; @(posedge core_clk) !rstn |=> servoPulse == '0; endproperty
    a_out_reset: assert property (p_out_reset) else $error("pulse not cleared");
    property p_unmapped; @(posedge core_clk) disable iff (!rstn)
        regRdEn && (regAddr > 8'h25 || regAddr == 8'h00) |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold; @(posedge core_clk) disable iff (!rstn)
        !regRdEn |=> $stable(regRdData); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_glob_back; @(posedge core_clk) disable iff (!rstn) regWrEn && regAddr == 8'h25
        ##1 !regWrEn ##1 regRdEn && regAddr == 8'h25 |=> regRdData == $past(regWrData, 3);
    endproperty
    a_glob_back: assert property (p_glob_back) else $error("global readback");
    property p_pos12_back; @(posedge core_clk) disable iff (!rstn) regWrEn && regAddr == 8'h17
        ##1 !regWrEn ##1 regRdEn && regAddr == 8'h17 |=> regRdData == $past(regWrData, 3);
    endproperty
    a_pos12_back: assert property (p_pos12_back) else $error("position readback");
    property p_pulse_min; @(posedge core_clk) disable iff (!rstn)
        $rose(servoPulse[11]) |-> servoPulse[11] [*8]; endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
    property p_idle; @(posedge core_clk) disable iff (!rstn)
        !armed_reg |-> servoPulse == '0 && servoMoving == '0; endproperty
    a_idle: assert property (p_idle) else $error("output before activation");
endmodule // scc_servo_control_sva
bind scc_servo_control scc_servo_control_sva #(.CH(CH)) u_chk (.core_clk(core_clk), .rstn(rstn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .servoPulse(servoPulse), .servoMoving(servoMoving));

// File: test_scc_servo_control.sv
// Self-checking testbench for the servo channel block
`timescale 1ns/1ps
module test_scc_servo_control;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    wire [7:0] regRdData;
    wire [17:0] servoPulse;
    wire [17:0] servoMoving;
    wire [15:0] widthSeen;
    wire [15:0] pulseCount;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] c;
    always #10 core_clk = ~core_clk;
    // Short frame so a run stays small; widths are 20 plus position
    scc_servo_control #(.CH(18), .FRAME_CYCLES(400), .PULSE_MIN_CYCLES(20),
        .PULSE_UNIT_CYCLES(1)) dut (.core_clk(core_clk), .rstn(rstn), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .servoPulse(servoPulse), .servoMoving(servoMoving));
    scc_servo_model servo12 (.core_clk(core_clk), .servoIn(servoPulse[11]),
        .widthSeen(widthSeen), .pulseCount(pulseCount));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
    endtask
    // Idle edge after each access keeps a strobe from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(posedge core_clk);
        cmp("read", {8'h00, exp}, {8'h00, regRdData});
    endtask
    task automatic next_width(output logic [15:0] w);
        logic [15:0] n;
        n = pulseCount;
        repeat (900) if (pulseCount == n) @(posedge core_clk);
        w = widthSeen;
    endtask
    // First pulse after a change is skipped, it may straddle the update
    task automatic chk_width(input logic [15:0] exp);
        logic [15:0] w;
        next_width(w);
        next_width(w);
        cmp("width", exp, w);
    endtask
    task automatic chk_step(input logic [15:0] d);
        logic [15:0] w1;
        logic [15:0] w2;
        next_width(w1);
        next_width(w1);
        next_width(w2);
        cmp("step", w1 + d, w2);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        do_reset();
        chk_rd(8'h17, 8'h80);
        chk_rd(8'h18, 8'h00);
        chk_rd(8'h25, 8'h00);
        wr(8'h30, 8'h5A);
        chk_rd(8'h30, 8'h00);
        wr(8'h17, 8'h40);
        chk_rd(8'h17, 8'h40);
        c = pulseCount;
        repeat (900) @(posedge core_clk);
        cmp("pulses", c, pulseCount);
        wr(8'h25, 8'hA5);
        chk_rd(8'h25, 8'hA5);
        chk_width(16'h0054);
        wr(8'h17, 8'h10);
        chk_width(16'h0054);
        wr(8'h18, 8'h40);
        wr(8'h25, 8'h01);
        chk_width(16'h0103);
        wr(8'h17, 8'h00);
        for (int s = 0; s < 16; s += 15) begin
            wr(8'h18, 8'h10 | s[7:0]);
            wr(8'h25, 8'h01);
            chk_step(16'h0000 - 16'(s + 1));
            cmp("moving", 16'h0001, {15'h0000, servoMoving[11]});
        end
        do_reset();
        wr(8'h18, 8'h20);
        wr(8'h25, 8'h01);
        chk_step(16'h0001);
        report_and_stop();
    end
endmodule // test_scc_servo_control
